// ===== rtl/hub_power_config_registers.sv
`timescale 1ns/1ps
// Function
// - self-powered max power byte, 2 mA units, reported when self-powered
// - bus-powered max power byte, 2 mA units, reported when bus-powered
// - max power fields include hub, board and zero-reporting peripheral
// - code fifty means 100 mA in every current field
// - controller self-powered current byte, 2 mA units, hub and board only
// - controller bus-powered current byte, 2 mA units, hub and board only
// - controller current fields exclude attached peripheral consumption
// - controller bus current nominally fifty, yet resets to zero
// - settle time byte, 2 ms units, power-on start to power good
// - reads of undefined offsets return zero
// - writes to undefined offsets are ignored without error
// - all five registers clear to zero on hardware reset
// - configuration is loaded after reset over the load interface
// - hardware reset returns internal registers to defaults
module hub_power_config_registers #(
    parameter int SETTLE_STEP_CYC = hub_power_cfg_pkg::SETTLE_STEP_CYCLES
) (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               cfg_wr_i,
    input  wire logic                               cfg_rd_i,
    input  wire logic [hub_power_cfg_pkg::ADDR_W-1:0] cfg_addr_i,
    input  wire logic [hub_power_cfg_pkg::DATA_W-1:0] cfg_wdata_i,
    input  wire logic                               self_powered_i,
    input  wire logic                               port_power_start_i,
    output logic      [hub_power_cfg_pkg::DATA_W-1:0] cfg_rdata_o,
    output logic      [hub_power_cfg_pkg::DATA_W-1:0] upstream_max_power_o,
    output logic      [hub_power_cfg_pkg::DATA_W-1:0] controller_current_o,
    output logic      [hub_power_cfg_pkg::DATA_W-1:0] settle_time_o,
    output logic                                    port_power_good_o
);
    import hub_power_cfg_pkg::*;

    logic [7:0]  self_supply_current_limit;
    logic [7:0]  bus_supply_current_limit;
    logic [7:0]  controller_only_self_current;
    logic [7:0]  controller_only_bus_current;
    logic [7:0]  port_power_settle_time;
    logic [7:0]  next_self_supply_current_limit;
    logic [7:0]  next_bus_supply_current_limit;
    logic [7:0]  next_controller_only_self_current;
    logic [7:0]  next_controller_only_bus_current;
    logic [7:0]  next_port_power_settle_time;
    logic [7:0]  next_cfg_rdata;
    logic [7:0]  next_upstream_max_power;
    logic [7:0]  next_controller_current;
    logic [31:0] step_cnt;
    logic [31:0] next_step_cnt;
    logic [8:0]  steps_left;
    logic [8:0]  next_steps_left;
    logic        settling;
    logic        next_settling;
    logic        next_power_good;

    always_comb begin
        next_self_supply_current_limit    = self_supply_current_limit;
        next_bus_supply_current_limit     = bus_supply_current_limit;
        next_controller_only_self_current = controller_only_self_current;
        next_controller_only_bus_current  = controller_only_bus_current;
        next_port_power_settle_time       = port_power_settle_time;
        // range checks are the loader's job, values are stored as given
        if (cfg_wr_i) begin
            unique case (cfg_addr_i)
                OFS_SELF_MAX_POWER:
                    next_self_supply_current_limit = cfg_wdata_i;
                OFS_BUS_MAX_POWER:
                    next_bus_supply_current_limit = cfg_wdata_i;
                OFS_CTRL_CUR_SELF:
                    next_controller_only_self_current = cfg_wdata_i;
                OFS_CTRL_CUR_BUS:
                    next_controller_only_bus_current = cfg_wdata_i;
                OFS_SETTLE_TIME:    next_port_power_settle_time = cfg_wdata_i;
                default: ;
            endcase
        end
        next_cfg_rdata = UNDEFINED_READ;
        if (cfg_rd_i) begin
            unique case (cfg_addr_i)
                OFS_SELF_MAX_POWER: next_cfg_rdata = self_supply_current_limit;
                OFS_BUS_MAX_POWER:  next_cfg_rdata = bus_supply_current_limit;
                OFS_CTRL_CUR_SELF:
                    next_cfg_rdata = controller_only_self_current;
                OFS_CTRL_CUR_BUS:
                    next_cfg_rdata = controller_only_bus_current;
                OFS_SETTLE_TIME:    next_cfg_rdata = port_power_settle_time;
                default:            next_cfg_rdata = UNDEFINED_READ;
            endcase
        end
        // full figure includes peripheral, controller figure excludes it
        next_upstream_max_power = self_powered_i ?
            self_supply_current_limit :
            bus_supply_current_limit;
        next_controller_current = self_powered_i ?
            controller_only_self_current :
            controller_only_bus_current;
    end

    // settle timer: steps of SETTLE_STEP_CYC cycles, restart on each start
    always_comb begin
        next_step_cnt   = step_cnt;
        next_steps_left = steps_left;
        next_settling   = settling;
        next_power_good = port_power_good_o;
        if (port_power_start_i) begin
            next_settling   = 1'b1;
            next_power_good = 1'b0;
            next_step_cnt   = 32'h0;
            next_steps_left = {1'b0, port_power_settle_time};
        end else if (settling) begin
            if (steps_left == 9'h000) begin
                next_settling   = 1'b0;
                next_power_good = 1'b1;
            end else if (step_cnt == 32'(SETTLE_STEP_CYC - 1)) begin
                next_step_cnt   = 32'h0;
                next_steps_left = steps_left - 9'h001;
            end else begin
                next_step_cnt = step_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            self_supply_current_limit    <= REG_RESET_VALUE;
            bus_supply_current_limit     <= REG_RESET_VALUE;
            controller_only_self_current <= REG_RESET_VALUE;
            controller_only_bus_current  <= REG_RESET_VALUE;
            port_power_settle_time       <= REG_RESET_VALUE;
            cfg_rdata_o                  <= 8'h00;
            upstream_max_power_o         <= 8'h00;
            controller_current_o         <= 8'h00;
            settle_time_o                <= 8'h00;
            step_cnt                     <= 32'h0;
            steps_left                   <= 9'h000;
            settling                     <= 1'b0;
            port_power_good_o            <= 1'b0;
        end else begin
            self_supply_current_limit    <= next_self_supply_current_limit;
            bus_supply_current_limit     <= next_bus_supply_current_limit;
            controller_only_self_current <= next_controller_only_self_current;
            controller_only_bus_current  <= next_controller_only_bus_current;
            port_power_settle_time       <= next_port_power_settle_time;
            cfg_rdata_o                  <= next_cfg_rdata;
            upstream_max_power_o         <= next_upstream_max_power;
            controller_current_o         <= next_controller_current;
            settle_time_o                <= port_power_settle_time;
            step_cnt                     <= next_step_cnt;
            steps_left                   <= next_steps_left;
            settling                     <= next_settling;
            port_power_good_o            <= next_power_good;
        end
    end

    function automatic logic defined_ofs(input logic [7:0] a);
        defined_ofs = (a >= OFS_SELF_MAX_POWER) && (a <= OFS_SETTLE_TIME);
    endfunction : defined_ofs

    reset_clear_a: assert property (
        @(posedge clk_i) rst_i |=>
        (self_supply_current_limit == 8'h00) &&
        (bus_supply_current_limit == 8'h00) &&
        (controller_only_self_current == 8'h00) &&
        (controller_only_bus_current == 8'h00) &&
        (port_power_settle_time == 8'h00) && !port_power_good_o)
        else $error("registers not cleared by reset");
    undef_read_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cfg_rd_i && !defined_ofs(cfg_addr_i) |=> cfg_rdata_o == 8'h00)
        else $error("undefined read not zero");
    idle_read_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !cfg_rd_i |=> cfg_rdata_o == 8'h00)
        else $error("read data not zero when idle");
    undef_write_ignored_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cfg_wr_i && !defined_ofs(cfg_addr_i) |=>
        $stable(self_supply_current_limit) && $stable(bus_supply_current_limit)
        && $stable(controller_only_self_current)
        && $stable(controller_only_bus_current)
        && $stable(port_power_settle_time))
        else $error("undefined write changed state");
    settle_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cfg_wr_i && cfg_addr_i == OFS_SETTLE_TIME |=>
        port_power_settle_time == $past(cfg_wdata_i))
        else $error("settle time write not stored");
    settle_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cfg_rd_i && cfg_addr_i == OFS_SETTLE_TIME |=>
        cfg_rdata_o == $past(port_power_settle_time))
        else $error("settle time read back wrong");
    self_report_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        self_powered_i |=>
        upstream_max_power_o == $past(self_supply_current_limit))
        else $error("self-powered figure wrong");
    bus_report_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !self_powered_i |=>
        upstream_max_power_o == $past(bus_supply_current_limit))
        else $error("bus-powered figure wrong");
    ctrl_self_report_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        self_powered_i |=>
        controller_current_o == $past(controller_only_self_current))
        else $error("controller self figure wrong");
    ctrl_bus_report_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !self_powered_i |=>
        controller_current_o == $past(controller_only_bus_current))
        else $error("controller bus figure wrong");
    zero_settle_good_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_power_start_i && port_power_settle_time == 8'h00
        ##1 !port_power_start_i |=> port_power_good_o)
        else $error("zero settle time not good in two cycles");
    start_drops_good_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_power_start_i |=> !port_power_good_o)
        else $error("power good not dropped on start");
    // good must wait for the whole count, not rise on the first step
    settle_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        settling && steps_left != 9'h000 |=> !port_power_good_o)
        else $error("power good before settle count ran out");

    write_cov: cover property (@(posedge clk_i)
        cfg_wr_i && defined_ofs(cfg_addr_i));
    undef_cov: cover property (@(posedge clk_i)
        cfg_rd_i && !defined_ofs(cfg_addr_i));
    good_cov: cover property (@(posedge clk_i)
        $rose(port_power_good_o));
    settle_cov: cover property (@(posedge clk_i)
        settling && steps_left != 9'h000);
    code50_cov: cover property (@(posedge clk_i)
        controller_only_bus_current == CURRENT_100MA_CODE);
endmodule : hub_power_config_registers

// ===== pkg/hub_power_cfg_pkg.sv
package hub_power_cfg_pkg;
    localparam int         DATA_W    = 8;
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] OFS_SELF_MAX_POWER  = 8'h0C;
    localparam logic [7:0] OFS_BUS_MAX_POWER   = 8'h0D;
    localparam logic [7:0] OFS_CTRL_CUR_SELF   = 8'h0E;
    localparam logic [7:0] OFS_CTRL_CUR_BUS    = 8'h0F;
    localparam logic [7:0] OFS_SETTLE_TIME     = 8'h10;
    localparam logic [7:0] REG_RESET_VALUE     = 8'h00;
    localparam logic [7:0] UNDEFINED_READ      = 8'h00;
    // current fields count in 2 mA steps, settle time in 2 ms steps
    localparam int         CURRENT_STEP_MA     = 2;
    localparam int         SETTLE_STEP_MS      = 2;
    localparam int         CLK_MHZ             = 125;
    localparam int         SETTLE_STEP_CYCLES  =
        SETTLE_STEP_MS * 1000 * CLK_MHZ;
    // value documented as meaning 100 mA; reset value is still zero
    localparam logic [7:0] CURRENT_100MA_CODE  = 8'h32;
endpackage : hub_power_cfg_pkg

// ===== testbench/hub_cfg_loader.sv
`timescale 1ns/1ps
module hub_cfg_loader (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    import hub_power_cfg_pkg::*;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if ((a == OFS_SELF_MAX_POWER || a == OFS_CTRL_CUR_SELF)
            && d > CURRENT_100MA_CODE) v = CURRENT_100MA_CODE;
        if (a < OFS_SELF_MAX_POWER || a > OFS_SETTLE_TIME) v = 8'h00;
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= v;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // released lines show the inverse, not a stale copy
        addr_o <= ~a;
        wdata_o <= ~v;
    endtask : write_byte
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask : read_byte
endmodule : hub_cfg_loader

// ===== testbench/hub_power_config_registers_test.sv
`timescale 1ns/1ps
module hub_power_config_registers_test;
    import hub_power_cfg_pkg::*;
    localparam int STEP = 4;
    logic       clk_i = 1'b0, rst_i = 1'b1, sp = 1'b0, start = 1'b0;
    logic       wr, rd, good;
    logic [7:0] addr, wdata, rdata, up, ctl, st, d;
    int         error_cnt = 0, comparisons = 0, n;
    logic [7:0] ofs [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
    // 0x32 is the 100 mA code
    logic [7:0] val [5] = '{8'h32, 8'hC8, 8'h19, 8'h32, 8'h03};
    initial forever #4 clk_i = ~clk_i;
    hub_power_config_registers #(.SETTLE_STEP_CYC(STEP)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_addr_i(addr), .cfg_wdata_i(wdata), .self_powered_i(sp),
        .port_power_start_i(start), .cfg_rdata_o(rdata),
        .upstream_max_power_o(up), .controller_current_o(ctl),
        .settle_time_o(st), .port_power_good_o(good));
    hub_cfg_loader i_loader (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_zero_state();
        for (int i = 0; i < 5; i++) begin
            i_loader.read_byte(ofs[i], d);
            check(d, REG_RESET_VALUE);
        end
        check(up, 8'h00);
        check(ctl, 8'h00);
        check(st, 8'h00);
        check(8'(good), 8'h00);
        $display("zero state test done");
    endtask : test_zero_state
    task automatic test_readback();
        for (int i = 0; i < 5; i++) i_loader.write_byte(ofs[i], val[i]);
        for (int i = 0; i < 5; i++) begin
            i_loader.read_byte(ofs[i], d);
            check(d, val[i]);
        end
        foreach (val[i]) i_loader.write_byte(8'h1C + 8'(i), 8'h00);
        i_loader.write_byte(8'h0B, 8'h00);
        foreach (val[i]) begin
            i_loader.read_byte(ofs[i], d);
            check(d, val[i]);
        end
        @(posedge clk_i) #1 check(rdata, 8'h00);
        i_loader.read_byte(8'h0B, d);
        check(d, UNDEFINED_READ);
        i_loader.read_byte(8'h11, d);
        check(d, UNDEFINED_READ);
        $display("readback test done");
    endtask : test_readback
    task automatic test_power_select();
        @(posedge clk_i) sp <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 check(up, val[0]);
        check(ctl, val[2]);
        check(st, val[4]);
        @(posedge clk_i) sp <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 check(up, val[1]);
        check(ctl, val[3]);
        $display("power select test done");
    endtask : test_power_select
    task automatic test_settle(input logic [7:0] t);
        i_loader.write_byte(OFS_SETTLE_TIME, t);
        @(posedge clk_i) start <= 1'b1;
        @(posedge clk_i) start <= 1'b0;
        #1 check(8'(good), 8'h00);
        n = 1;
        while (good !== 1'b1 && n < 60) begin
            @(posedge clk_i) #1 n++;
        end
        // delay is the settle count in steps plus the fixed two-cycle lag
        check(8'(n), 8'(32'(t) * STEP + 2));
        $display("settle test done");
    endtask : test_settle
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        #40000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        test_zero_state();
        test_readback();
        test_power_select();
        test_settle(8'h03);
        test_settle(8'h00);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        test_zero_state();
        tally_and_finish();
    end
endmodule : hub_power_config_registers_test
